// *** hw/cfr_defs.svh ***
// cfr_defs.svh: offsets, field positions and reset values of the fault router
// assumes a 12-bit byte address space, one 32-bit word per register
`ifndef CFR_DEFS_SVH
`define CFR_DEFS_SVH

// global registers (byte addresses)
`define CFR_S_CTL0      12'h000
`define CFR_S_CTL1      12'h004
`define CFR_NS_CTL0     12'h008
`define CFR_S_FSTA      12'h00C
`define CFR_NS_FSTA     12'h010
`define CFR_S_SYN       12'h014
`define CFR_S_FADDR     12'h018
`define CFR_NS_FADDR    12'h01C
`define CFR_GRES        12'h020

// context bank region: bit 11 set, bank in bit 8, word in bits 3:2
`define CFR_CB_REGION   11
`define CFR_CB_SEL      8
`define CFR_CB_CTL      2'h0
`define CFR_CB_FSTA     2'h1
`define CFR_CB_FADDR    2'h2
`define CFR_CB_RES      2'h3

// control zero fields
`define CFR_GLB_REP_EN  0
`define CFR_CFG_REP_EN  1
`define CFR_CFG_INT_EN  2
`define CFR_GLB_INT_EN  3
`define CFR_PRIV_TLB    4
`define CFR_VM_PRIV_NS  5

// control one fields
`define CFR_NS_CFG_REDIR 0
`define CFR_SEC_ONLY     1
`define CFR_EXT_REDIR    2

// fault status fields
`define CFR_EXT_FLAG    0
`define CFR_CFG_FLAG    1
`define CFR_MULTI       2

// context control fields
`define CFR_CTX_REP_EN  0
`define CFR_CTX_STALL   1
`define CFR_HIT_PRIOR   2

// reset values
`define CFR_CTL0_RST    6'h00
`define CFR_CTL1_RST    3'h0
`define CFR_CB_CTL_RST  3'h0
`define CFR_FSTA_RST    3'h0

`endif

// *** hw/cfr_pkg.sv ***
// cfr_pkg: types shared by the fault router modules
// assumes cfr_defs.svh carries all numeric constants
package cfr_pkg;

   typedef enum logic [1:0] {
      CFR_GRP_SEC = 2'b00,
      CFR_GRP_NS  = 2'b01,
      CFR_GRP_CB0 = 2'b10,
      CFR_GRP_CB1 = 2'b11
   } cfr_grp_e;

   typedef enum logic [1:0] {
      CFR_RSP_OK     = 2'b00,
      CFR_RSP_EXFAIL = 2'b01,
      CFR_RSP_ABORT  = 2'b10
   } cfr_rsp_e;

   typedef enum logic [1:0] {
      CFR_RES_OK    = 2'b00,
      CFR_RES_FAULT = 2'b01,
      CFR_RES_TERM  = 2'b10
   } cfr_res_e;

endpackage

// *** hw/cfr_ext_if.sv ***
// cfr_ext_if: external abort description and the group chosen for it
// assumes the source and router share one clock
`timescale 1ns/1ps
interface cfr_ext_if;
   import cfr_pkg::*;
   logic     abt;
   logic     sync;
   logic     bypass;
   logic     nested;
   logic     ns;
   logic     ns_known;
   logic     cb;
   logic     s2cb;
   logic     redir;
   logic     rec;
   logic     fwd;
   logic     far_we;
   cfr_grp_e grp;
   modport src (output abt, sync, bypass, nested, ns, ns_known, cb, s2cb, redir,
                input rec, fwd, far_we, grp);
   modport rtr (input abt, sync, bypass, nested, ns, ns_known, cb, s2cb, redir,
                output rec, fwd, far_we, grp);
endinterface

// *** hw/cfr_ext_route.sv ***
// cfr_ext_route: picks the fault status group for an external abort
// assumes inputs are single-cycle pulses on the caller's clock
`timescale 1ns/1ps
module cfr_ext_route
   import cfr_pkg::*;
#(
   parameter bit UPSTREAM_ERR = 1'b0
) (
   cfr_ext_if.rtr ext
);

   cfr_grp_e glb;

   always_comb begin
      if (ext.redir)
         glb = CFR_GRP_SEC;
      else if (ext.ns_known && !ext.ns)
         glb = CFR_GRP_SEC;
      else
         glb = CFR_GRP_NS;
      ext.fwd    = ext.abt && UPSTREAM_ERR;
      ext.rec    = ext.abt && !UPSTREAM_ERR;
      ext.far_we = ext.sync;
      if (!ext.sync || ext.bypass)
         ext.grp = glb;
      else if (ext.nested)
         ext.grp = ext.s2cb ? CFR_GRP_CB1 : CFR_GRP_CB0;
      else
         ext.grp = ext.cb ? CFR_GRP_CB1 : CFR_GRP_CB0;
   end

endmodule // cfr_ext_route

// *** hw/cfr_top.sv ***
// cfr_top: configuration access policing and external fault routing
// assumes a plain register port and same-clock fault event pulses
// Behaviour
// - unimplemented or Secure-only access reads zero or faults, by parameter
// - unimplemented bits of implemented registers read zero, ignore writes
// - unprivileged global access is read-zero or faults, by parameter
// - context bank accesses never fault; unknown ones read zero
// - Non-secure touching Secure faults into Secure status unless redirected
// - Secure config fault on empty Secure status raises interrupt when its enable is set; the multiple flag drops it
// - Secure config fault aborts the access when report enable set
// - redirect bit sends such faults to Non-secure status
// - Secure syndrome notes Non-secure origin; Non-secure faults leave it
// - Secure-only mode denies Non-secure global access, Secure-recorded unless redirected
// - walk aborts for client transactions go to the matching status
// - translation operation walk aborts land in result registers
// - external redirect sends globally recorded downstream aborts to Secure status
// - without upstream errors, bank aborts record in bank, rest globally
// - with upstream errors aborts forward; related bits read zero
// - bypass and asynchronous aborts go global, synchronous translated ones to their bank
// - nested translation aborts go to the stage 2 bank
// - synchronous abort loads status, address and syndrome
// - asynchronous abort updates status only, redirect forces Secure
// - exclusive fault aborts if reported, else returns failed
// - bank report and stall controls steer client context faults
// - broadcast invalidation ignored when private bits set
// - fault on nonzero status only sets the multiple flag
`timescale 1ns/1ps
`include "cfr_defs.svh"
module cfr_top
   import cfr_pkg::*;
#(
   parameter bit UNIMPL_FAULT  = 1'b1,
   parameter bit NS_FAULT      = 1'b1,
   parameter bit PRIV_RESTRICT = 1'b1,
   parameter bit PRIV_FAULT    = 1'b0,
   parameter bit UPSTREAM_ERR  = 1'b0,
   parameter bit CB1_SECURE    = 1'b1
) (
   input  wire logic        clk_in,
   input  wire logic        rst_b_in,
   input  wire logic [11:0] reg_addr_in,
   input  wire logic [31:0] reg_wdata_in,
   input  wire logic        reg_wr_in,
   input  wire logic        reg_rd_in,
   input  wire logic        reg_ns_in,
   input  wire logic        reg_priv_in,
   output logic      [31:0] reg_rdata_out,
   output logic             reg_abort_out,
   input  wire logic        ext_abt_in,
   input  wire logic        ext_sync_in,
   input  wire logic        ext_bypass_in,
   input  wire logic        ext_nested_in,
   input  wire logic        ext_ns_in,
   input  wire logic        ext_ns_known_in,
   input  wire logic        ext_cb_in,
   input  wire logic        ext_s2cb_in,
   input  wire logic [31:0] ext_addr_in,
   output logic             ext_fwd_out,
   input  wire logic        ats_abt_in,
   input  wire logic        ats_glob_in,
   input  wire logic        ats_s2_in,
   input  wire logic        ats_cb_in,
   input  wire logic        ats_s2cb_in,
   input  wire logic [31:0] ats_addr_in,
   input  wire logic        excl_abt_in,
   input  wire logic        excl_glob_in,
   input  wire logic        excl_ns_in,
   input  wire logic        excl_cb_in,
   output logic      [1:0]  excl_resp_out,
   input  wire logic        ctx_flt_in,
   input  wire logic        ctx_cb_in,
   output logic             ctx_report_out,
   output logic             ctx_stall_out,
   input  wire logic        tlbi_bcast_in,
   output logic             tlbi_apply_out,
   output logic             s_cfg_irq_out,
   output logic             s_glb_irq_out,
   output logic             ns_cfg_irq_out,
   output logic             ns_glb_irq_out,
   output logic      [1:0]  hit_prior_out
);

   // status group address
   function automatic logic [11:0] fsta_addr(input int g);
      if (g == 0)
         return `CFR_S_FSTA;
      if (g == 1)
         return `CFR_NS_FSTA;
      return {1'b1, 2'b00, g[0], 4'h0, `CFR_CB_FSTA, 2'b00};
   endfunction

   function automatic logic [11:0] faddr_addr(input int g);
      if (g == 0)
         return `CFR_S_FADDR;
      if (g == 1)
         return `CFR_NS_FADDR;
      return {1'b1, 2'b00, g[0], 4'h0, `CFR_CB_FADDR, 2'b00};
   endfunction

   logic [5:0]  s_ctl0;
   logic [5:0]  ns_ctl0;
   logic [2:0]  s_ctl1;
   logic [2:0]  fsta    [4];
   logic [31:0] faddr   [4];
   logic        s_syn;
   logic        gres;
   logic [2:0]  cb_ctl  [2];
   logic [1:0]  cb_res  [2];

   logic        glob;
   logic        cbi;
   logic        hit;
   logic        sec_reg;
   logic        acc;
   logic        ns_deny;
   logic        priv_deny;
   logic        unimpl;
   logic        cb_deny;
   logic        blocked;
   logic        wr_ok;
   logic        cfg_flt;
   logic        cfg_to_sec;
   logic [31:0] rval;
   logic [3:0]  cfg_ev;
   logic [3:0]  ext_ev;
   logic [2:0]  fsta_clr [4];

   cfr_ext_if ext ();

   assign ext.abt      = ext_abt_in;
   assign ext.sync     = ext_sync_in;
   assign ext.bypass   = ext_bypass_in;
   assign ext.nested   = ext_nested_in;
   assign ext.ns       = ext_ns_in;
   assign ext.ns_known = ext_ns_known_in;
   assign ext.cb       = ext_cb_in;
   assign ext.s2cb     = ext_s2cb_in;
   assign ext.redir    = s_ctl1[`CFR_EXT_REDIR];

   cfr_ext_route #(
      .UPSTREAM_ERR (UPSTREAM_ERR)
   ) u_route (
      .ext (ext)
   );

   // register decode and read values
   always_comb begin
      glob    = !reg_addr_in[`CFR_CB_REGION];
      cbi     = reg_addr_in[`CFR_CB_SEL];
      hit     = 1'b1;
      sec_reg = 1'b0;
      rval    = 32'h0000_0000;
      if (glob) begin
         case (reg_addr_in)
            `CFR_S_CTL0: begin
               sec_reg = 1'b1;
               rval    = {26'h0, s_ctl0};
            end
            `CFR_S_CTL1: begin
               sec_reg = 1'b1;
               rval    = {29'h0, s_ctl1};
            end
            `CFR_NS_CTL0:  rval = {26'h0, ns_ctl0};
            `CFR_S_FSTA: begin
               sec_reg = 1'b1;
               rval    = {29'h0, fsta[0]};
            end
            `CFR_NS_FSTA:  rval = {29'h0, fsta[1]};
            `CFR_S_SYN: begin
               sec_reg = 1'b1;
               rval    = {31'h0, s_syn & !UPSTREAM_ERR};
            end
            `CFR_S_FADDR: begin
               sec_reg = 1'b1;
               rval    = faddr[0];
            end
            `CFR_NS_FADDR: rval = faddr[1];
            `CFR_GRES:     rval = {31'h0, gres};
            default:       hit  = 1'b0;
         endcase
      end else if (reg_addr_in[10:9] != 2'b00 || reg_addr_in[7:4] != 4'h0) begin
         hit = 1'b0;
      end else begin
         case (reg_addr_in[3:2])
            `CFR_CB_CTL:   rval = {29'h0, cb_ctl[cbi]};
            `CFR_CB_FSTA:  rval = {29'h0, fsta[{1'b1, cbi}]};
            `CFR_CB_FADDR: rval = faddr[{1'b1, cbi}];
            `CFR_CB_RES:   rval = {30'h0, cb_res[cbi]};
            default:       hit  = 1'b0;
         endcase
      end
   end

   // access checks
   always_comb begin
      acc        = reg_wr_in || reg_rd_in;
      ns_deny    = glob && reg_ns_in && (sec_reg || s_ctl1[`CFR_SEC_ONLY]);
      priv_deny  = glob && PRIV_RESTRICT && !reg_priv_in;
      unimpl     = glob && !hit;
      cb_deny    = !glob && reg_ns_in && cbi && CB1_SECURE;
      blocked    = ns_deny || priv_deny || unimpl || cb_deny || !hit;
      wr_ok      = reg_wr_in && !blocked;
      cfg_flt    = acc && ((unimpl && UNIMPL_FAULT) || (ns_deny && NS_FAULT)
                   || (priv_deny && PRIV_FAULT));
      cfg_to_sec = ns_deny ? !s_ctl1[`CFR_NS_CFG_REDIR] : !reg_ns_in;
   end

   // per-group events
   always_comb begin
      cfg_ev = 4'h0;
      ext_ev = 4'h0;
      if (cfg_flt)
         cfg_ev[cfg_to_sec ? 0 : 1] = 1'b1;
      if (ext.rec)
         ext_ev[ext.grp] = 1'b1;
      if (ats_abt_in && !ats_glob_in && ats_s2_in)
         ext_ev[{1'b1, ats_s2cb_in}] = 1'b1;
      for (int g = 0; g < 4; g++)
         fsta_clr[g] = (wr_ok && reg_addr_in == fsta_addr(g)) ? reg_wdata_in[2:0] : 3'h0;
   end

   // control registers
   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         s_ctl0  <= `CFR_CTL0_RST;
         ns_ctl0 <= `CFR_CTL0_RST;
         s_ctl1  <= `CFR_CTL1_RST;
         cb_ctl  <= '{`CFR_CB_CTL_RST, `CFR_CB_CTL_RST};
      end else if (wr_ok) begin
         if (reg_addr_in == `CFR_S_CTL0)
            s_ctl0 <= reg_wdata_in[5:0];
         if (reg_addr_in == `CFR_NS_CTL0)
            ns_ctl0 <= reg_wdata_in[5:0];
         if (reg_addr_in == `CFR_S_CTL1)
            s_ctl1 <= {reg_wdata_in[2] & !UPSTREAM_ERR, reg_wdata_in[1:0]};
         if (!glob && reg_addr_in[3:2] == `CFR_CB_CTL)
            cb_ctl[cbi] <= reg_wdata_in[2:0];
      end
   end

   // fault status, address and syndrome
   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         fsta  <= '{`CFR_FSTA_RST, `CFR_FSTA_RST, `CFR_FSTA_RST, `CFR_FSTA_RST};
         faddr <= '{32'h0, 32'h0, 32'h0, 32'h0};
         s_syn <= 1'b0;
      end else begin
         for (int g = 0; g < 4; g++) begin
            if (cfg_ev[g] || ext_ev[g]) begin
               if (fsta[g] != 3'h0 || (cfg_ev[g] && ext_ev[g]))
                  fsta[g] <= (fsta[g] & ~fsta_clr[g]) | 3'h4;
               else begin
                  fsta[g] <= {1'b0, cfg_ev[g], ext_ev[g]};
                  if (cfg_ev[g])
                     faddr[g] <= {20'h0, reg_addr_in};
                  else if (ext.rec && ext.far_we)
                     faddr[g] <= ext_addr_in;
                  else if (!ext.rec)
                     faddr[g] <= ats_addr_in;
               end
            end else begin
               fsta[g] <= fsta[g] & ~fsta_clr[g];
               if (wr_ok && reg_addr_in == faddr_addr(g))
                  faddr[g] <= reg_wdata_in;
            end
         end
         if (fsta[0] == 3'h0) begin
            if (cfg_ev[0] && !ext_ev[0])
               s_syn <= reg_ns_in;
            else if (ext_ev[0] && !cfg_ev[0] && ext.far_we)
               s_syn <= ext_ns_in;
         end
      end
   end

   // translation operation results
   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         gres   <= 1'b0;
         cb_res <= '{CFR_RES_OK, CFR_RES_OK};
      end else if (ats_abt_in) begin
         if (ats_glob_in)
            gres <= 1'b1;
         else
            cb_res[ats_cb_in] <= ats_s2_in ? CFR_RES_TERM : CFR_RES_FAULT;
      end else if (wr_ok && reg_addr_in == `CFR_GRES) begin
         gres <= reg_wdata_in[0];
      end
   end

   // register read and abort answers
   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         reg_rdata_out <= 32'h0000_0000;
         reg_abort_out <= 1'b0;
      end else begin
         reg_rdata_out <= (reg_rd_in && !blocked) ? rval : 32'h0000_0000;
         reg_abort_out <= cfg_flt && (cfg_to_sec ? s_ctl0[`CFR_CFG_REP_EN]
                                                : ns_ctl0[`CFR_CFG_REP_EN]);
      end
   end

   // fault interrupt levels
   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         s_cfg_irq_out  <= 1'b0;
         s_glb_irq_out  <= 1'b0;
         ns_cfg_irq_out <= 1'b0;
         ns_glb_irq_out <= 1'b0;
      end else begin
         s_cfg_irq_out  <= fsta[0][`CFR_CFG_FLAG] && !fsta[0][`CFR_MULTI] && s_ctl0[`CFR_CFG_INT_EN];
         s_glb_irq_out  <= (fsta[0][`CFR_EXT_FLAG] || fsta[0][`CFR_MULTI]) && s_ctl0[`CFR_GLB_INT_EN];
         ns_cfg_irq_out <= fsta[1][`CFR_CFG_FLAG] && !fsta[1][`CFR_MULTI] && ns_ctl0[`CFR_CFG_INT_EN];
         ns_glb_irq_out <= (fsta[1][`CFR_EXT_FLAG] || fsta[1][`CFR_MULTI]) && ns_ctl0[`CFR_GLB_INT_EN];
      end
   end

   // client-side responses
   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         excl_resp_out  <= CFR_RSP_OK;
         ctx_report_out <= 1'b0;
         ctx_stall_out  <= 1'b0;
         tlbi_apply_out <= 1'b0;
         ext_fwd_out    <= 1'b0;
         hit_prior_out  <= 2'b00;
      end else begin
         if (!excl_abt_in)
            excl_resp_out <= CFR_RSP_OK;
         else if (excl_glob_in ? (excl_ns_in ? ns_ctl0[`CFR_GLB_REP_EN] : s_ctl0[`CFR_GLB_REP_EN])
                               : cb_ctl[excl_cb_in][`CFR_CTX_REP_EN])
            excl_resp_out <= CFR_RSP_ABORT;
         else
            excl_resp_out <= CFR_RSP_EXFAIL;
         ctx_report_out <= ctx_flt_in && cb_ctl[ctx_cb_in][`CFR_CTX_REP_EN];
         ctx_stall_out  <= ctx_flt_in && cb_ctl[ctx_cb_in][`CFR_CTX_STALL];
         tlbi_apply_out <= tlbi_bcast_in && !(s_ctl0[`CFR_PRIV_TLB] || s_ctl0[`CFR_VM_PRIV_NS]
                           || ns_ctl0[`CFR_PRIV_TLB] || ns_ctl0[`CFR_VM_PRIV_NS]);
         ext_fwd_out    <= ext.fwd;
         hit_prior_out  <= {cb_ctl[1][`CFR_HIT_PRIOR], cb_ctl[0][`CFR_HIT_PRIOR]};
      end
   end

   default clocking cb_clk @(posedge clk_in);
   endclocking
   default disable iff (!rst_b_in);

   AST_CB_NO_FAULT: assert property (
      acc && !glob |=> !reg_abort_out)
      else $error("bank access aborted");
   AST_SEC_RECORD: assert property (
      cfg_flt && ns_deny && !s_ctl1[0] && fsta[0] == 3'h0 && !ext_ev[0]
      |=> fsta[0] == 3'h2 && s_syn)
      else $error("secure config fault not recorded");
   AST_NS_REDIRECT: assert property (
      cfg_flt && ns_deny && s_ctl1[0] |=> fsta[1] != 3'h0 && $stable(s_syn))
      else $error("redirected fault misrouted");
   AST_ABORT: assert property (
      cfg_flt && cfg_to_sec && s_ctl0[1] |=> reg_abort_out)
      else $error("missing config abort");
   AST_MULTI: assert property (
      (cfg_ev[0] || ext_ev[0]) && fsta[0] != 3'h0 |=> fsta[0][2] && $stable(faddr[0]))
      else $error("multi fault overwrote state");
   AST_IRQ_LEVEL: assert property (
      s_ctl0[2] && fsta[0] == 3'h2 |=> s_cfg_irq_out)
      else $error("config irq dropped");
   AST_IRQ_CLEAR: assert property (
      !fsta[0][`CFR_CFG_FLAG] |=> !s_cfg_irq_out)
      else $error("config irq without status");
   AST_TLBI: assert property (
      tlbi_bcast_in && (s_ctl0[4] || ns_ctl0[4]) |=> !tlbi_apply_out)
      else $error("private maintenance applied");
   AST_EXCL: assert property (
      excl_abt_in && !excl_glob_in && !cb_ctl[excl_cb_in][0] |=> excl_resp_out == CFR_RSP_EXFAIL)
      else $error("exclusive fault not failed");
   AST_FWD: assert property (
      ext_abt_in |=> ext_fwd_out == UPSTREAM_ERR)
      else $error("forward mismatch");

endmodule // cfr_top

// *** testbench/cfr_event_model.sv ***
// cfr_event_model: far-side source of fault, exclusive, context and invalidation events
// assumes one shared clock; events are one-cycle pulses launched just after a rising edge
`timescale 1ns/1ps
module cfr_event_model (
   input  wire logic        clk_in,
   output logic      [19:0] ev_out,
   output logic      [31:0] addr_out
);
   initial begin
      ev_out   = '0;
      addr_out = '0;
   end
   // one-cycle pulse, address then scrambled once released
   task automatic fire(input logic [19:0] v, input logic [31:0] a);
      @(posedge clk_in);
      ev_out   <= v;
      addr_out <= a;
      @(posedge clk_in);
      ev_out   <= '0;
      addr_out <= ~a;
   endtask
endmodule // cfr_event_model

// *** testbench/test_config_access_and_external_fault_router.sv ***
// test_config_access_and_external_fault_router: directed register and fault event tests
// assumes default parameters of cfr_top and the event model as far side
`timescale 1ns/1ps
module test_config_access_and_external_fault_router;
   import cfr_pkg::*;
   logic        clk_in = 0, rst_b_in = 0, reg_wr_in = 0, reg_rd_in = 0, reg_ns_in = 0, reg_priv_in = 1;
   logic [11:0] reg_addr_in = '0;
   logic [31:0] reg_wdata_in = '0, d;
   logic        ab;
   int          failures = 0, num_checks = 0;
   wire  [31:0] reg_rdata_out, ext_addr_in, ats_addr_in, ev_addr;
   wire  [19:0] ev;
   wire  [1:0]  excl_resp_out, hit_prior_out;
   wire reg_abort_out, ext_fwd_out, ctx_report_out, ctx_stall_out, tlbi_apply_out;
   wire s_cfg_irq_out, s_glb_irq_out, ns_cfg_irq_out, ns_glb_irq_out;
   wire ext_abt_in, ext_sync_in, ext_bypass_in, ext_nested_in, ext_ns_in, ext_ns_known_in, ext_cb_in, ext_s2cb_in;
   wire ats_abt_in, ats_glob_in, ats_s2_in, ats_cb_in, ats_s2cb_in, excl_abt_in, excl_glob_in, excl_ns_in;
   wire excl_cb_in, ctx_flt_in, ctx_cb_in, tlbi_bcast_in;
   assign {ext_abt_in, ext_sync_in, ext_bypass_in, ext_nested_in, ext_ns_in, ext_ns_known_in, ext_cb_in, ext_s2cb_in,
           ats_abt_in, ats_glob_in, ats_s2_in, ats_cb_in, ats_s2cb_in, excl_abt_in, excl_glob_in, excl_ns_in,
           excl_cb_in, ctx_flt_in, ctx_cb_in, tlbi_bcast_in} = ev;
   assign ext_addr_in = ev_addr;
   assign ats_addr_in = ev_addr;

   cfr_top dut (.*);
   cfr_event_model src (.clk_in(clk_in), .ev_out(ev), .addr_out(ev_addr));

   always #2.5 clk_in = ~clk_in;

   task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value %s expected %h seen %h", n, exp, seen);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic ns);
      @(posedge clk_in);
      reg_addr_in  <= a;
      reg_wdata_in <= v;
      reg_ns_in    <= ns;
      reg_wr_in    <= 1'b1;
      @(posedge clk_in);
      reg_wr_in    <= 1'b0;
      #1 ab = reg_abort_out;
   endtask
   task automatic rd(input logic [11:0] a, input logic ns);
      @(posedge clk_in);
      reg_addr_in <= a;
      reg_ns_in   <= ns;
      reg_rd_in   <= 1'b1;
      @(posedge clk_in);
      reg_rd_in   <= 1'b0;
      #1 d = reg_rdata_out;
   endtask
   task automatic fev(input logic [19:0] v, input logic [31:0] a);
      src.fire(v, a);
      #1;
   endtask
   task automatic finish_test;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   initial begin
      #100000;
      failures++;
      finish_test;
   end

   initial begin
      repeat (12) @(posedge clk_in);
      rst_b_in <= 1'b1;
      rd(12'h000, 0);
      chk("ctl0 reset", d, 32'h0);
      rd(12'h00C, 0);
      chk("s status reset", d, 32'h0);
      wr(12'h000, 32'hFFFFFFFF, 0);
      rd(12'h000, 0);
      chk("ctl0 bits", d, 32'h3F);
      wr(12'h000, 32'h06, 0);
      $display("test reset and fields done");
      wr(12'h004, 32'h1, 1);
      chk("ns abort", ab, 1);
      rd(12'h00C, 0);
      chk("s cfg flag", d, 32'h2);
      rd(12'h014, 0);
      chk("ns origin", d, 32'h1);
      chk("s cfg irq", s_cfg_irq_out, 1);
      rd(12'h004, 0);
      chk("ctl1 ignored", d, 32'h0);
      wr(12'h00C, 32'h7, 0);
      repeat (2) @(posedge clk_in);
      #1;
      chk("s cfg irq off", s_cfg_irq_out, 0);
      wr(12'h000, 32'h0, 1);
      wr(12'h004, 32'h0, 1);
      rd(12'h00C, 0);
      chk("multi", d, 32'h6);
      rd(12'h018, 0);
      chk("multi addr kept", d, 32'h0);
      wr(12'h00C, 32'h7, 0);
      $display("test secure config fault done");
      wr(12'h008, 32'h6, 1);
      wr(12'h004, 32'h1, 0);
      wr(12'h000, 32'h0, 1);
      chk("ns group abort", ab, 1);
      rd(12'h010, 1);
      chk("ns status", d, 32'h2);
      rd(12'h00C, 0);
      chk("s status clean", d, 32'h0);
      rd(12'h014, 0);
      chk("syndrome kept", d, 32'h1);
      chk("ns cfg irq", ns_cfg_irq_out, 1);
      wr(12'h010, 32'h7, 1);
      wr(12'h910, 32'h1, 1);
      chk("bank no abort", ab, 0);
      rd(12'h010, 1);
      chk("bank no fault", d, 32'h0);
      $display("test redirect and bank space done");
      wr(12'h004, 32'h4, 0);
      fev(20'hE0000, 32'h1111_0000);
      chk("no forward", ext_fwd_out, 0);
      rd(12'h00C, 0);
      chk("bypass to s", d, 32'h1);
      rd(12'h018, 0);
      chk("s fault addr", d, 32'h1111_0000);
      fev(20'hC2000, 32'h2222_0000);
      rd(12'h904, 0);
      chk("bank1 ext", d, 32'h1);
      rd(12'h908, 0);
      chk("bank1 addr", d, 32'h2222_0000);
      fev(20'hD2000, 32'h3333_0000);
      rd(12'h804, 0);
      chk("nested s2", d, 32'h1);
      fev(20'hC2000, 32'h4444_0000);
      rd(12'h904, 0);
      chk("bank1 multi", d, 32'h5);
      rd(12'h908, 0);
      chk("bank1 addr kept", d, 32'h2222_0000);
      rd(12'h904, 1);
      chk("bank ns raz", d, 32'h0);
      wr(12'h00C, 32'h7, 0);
      fev(20'h80000, 32'h5555_0000);
      rd(12'h00C, 0);
      chk("async to s", d, 32'h1);
      rd(12'h018, 0);
      chk("async no addr", d, 32'h1111_0000);
      wr(12'h000, 32'h0E, 0);
      wr(12'h804, 32'h7, 0);
      fev(20'h00B00, 32'h6666_0000);
      rd(12'h804, 0);
      chk("op abort s2 status", d, 32'h1);
      rd(12'h808, 0);
      chk("op abort s2 addr", d, 32'h6666_0000);
      rd(12'h90C, 0);
      chk("op terminated", d, 32'h2);
      fev(20'h00C00, 0);
      rd(12'h020, 0);
      chk("global op result", d, 32'h1);
      chk("s glb irq", s_glb_irq_out, 1);
      $display("test external aborts done");
      fev(20'h00060, 0);
      chk("excl failed", excl_resp_out, CFR_RSP_EXFAIL);
      wr(12'h000, 32'h07, 0);
      fev(20'h00060, 0);
      chk("excl abort", excl_resp_out, CFR_RSP_ABORT);
      fev(20'h00001, 0);
      chk("tlbi applied", tlbi_apply_out, 1);
      wr(12'h000, 32'h17, 0);
      fev(20'h00001, 0);
      chk("tlbi refused", tlbi_apply_out, 0);
      // hit-under-fault set by software when stage 2 is shared
      wr(12'h800, 32'h7, 0);
      fev(20'h00004, 0);
      chk("ctx report", ctx_report_out, 1);
      chk("ctx stall", ctx_stall_out, 1);
      chk("hit prior", hit_prior_out, 2'b01);
      fev(20'h00040, 0);
      chk("ctx excl abort", excl_resp_out, CFR_RSP_ABORT);
      fev(20'h00048, 0);
      chk("ctx excl failed", excl_resp_out, CFR_RSP_EXFAIL);
      $display("test responses done");
      wr(12'h00C, 32'h7, 0);
      wr(12'h004, 32'h2, 0);
      rd(12'h008, 1);
      chk("secure only raz", d, 32'h0);
      rd(12'h00C, 0);
      chk("secure only fault", d, 32'h2);
      @(posedge clk_in);
      reg_priv_in <= 1'b0;
      rd(12'h000, 0);
      chk("unpriv raz", d, 32'h0);
      $display("test privilege done");
      finish_test;
   end
endmodule // test_config_access_and_external_fault_router
